// *** dv/ach_chk.sv ***
// pin-level assertions for the converter handshake
`timescale 1ns/1ps
`include "ach_defines.svh"
module ach_chk (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic conversion_start_n,
  input wire logic busy_n,
  input wire logic [`ACH_DATA_W-1:0] data
);
  localparam int CONV_CYC = `ACH_CONV_CYC;
  localparam int MAX_CYC = `ACH_CONV_MAX_NS / `ACH_CLK_PERIOD_NS;
  localparam int THRU_CYC = `ACH_THRU_CYC;
  logic [4:0] lo_cnt_reg;
  logic [5:0] gap_cnt_reg;
  logic start_last_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // busy low time, counted in sampled cycles
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) lo_cnt_reg <= 5'h00;
    else if (busy_n) lo_cnt_reg <= 5'h00;
    else lo_cnt_reg <= lo_cnt_reg + 5'h01;
  end
  // start spacing, saturating so the first start after reset passes
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_cnt_reg <= 6'h3F;
      start_last_reg <= 1'b1;
    end else begin
      start_last_reg <= conversion_start_n;
      if (start_last_reg && !conversion_start_n) gap_cnt_reg <= 6'h00;
      else if (gap_cnt_reg != 6'h3F) gap_cnt_reg <= gap_cnt_reg + 6'h01;
    end
  end
  sequence s_idle_start;
    $fell(conversion_start_n) && busy_n;
  endsequence
  sequence s_conv_end;
    $rose(busy_n);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  start_accept_a: assert property (s_idle_start |-> ##[2:5] !busy_n)
    else $error("idle start edge not accepted");
  fall_cause_a: assert property ($fell(busy_n) |-> !$past(conversion_start_n, 3))
    else $error("busy fell without a start edge");
  conv_len_a: assert property (s_conv_end |-> int'(lo_cnt_reg) == CONV_CYC)
    else $error("conversion length wrong");
  conv_max_a: assert property (!busy_n |-> int'(lo_cnt_reg) < MAX_CYC)
    else $error("conversion too long");
  busy_low_a: assert property ($fell(busy_n) |-> (!busy_n)[*8])
    else $error("busy rose early");
  data_hold_a: assert property (!$rose(busy_n) |-> $stable(data))
    else $error("data moved outside busy rise");
  busy_hold_a: assert property (conversion_start_n[*5] ##0 busy_n |=> busy_n)
    else $error("busy fell with no start");
  rise_hold_a: assert property (s_conv_end |-> busy_n[*3])
    else $error("busy fell right after rise");
  start_gap_a: assert property ($fell(conversion_start_n) |-> int'(gap_cnt_reg) >= THRU_CYC - 1)
    else $error("starts closer than throughput time");
endmodule // ach_chk

// *** dv/test_adc_conversion_handshake.sv ***
// bench: host and converter joined, plus a converter driven directly
`timescale 1ns/1ps
`include "ach_defines.svh"
module test_adc_conversion_handshake;
  import ach_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start_req_i = 1'b0;
  logic ref_changed_i = 1'b0;
  logic ready_o, result_valid_o, prev_busy;
  ach_word_t sample_i = 14'h0000;
  ach_word_t sample2_i = 14'h0000;
  ach_word_t result_o;
  ach_word_t last_w = 14'h0000;
  ach_word_t exp_q[$];
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'hc2b6;
  int cyc, rise_age;
  ach_if link ();
  ach_if link2 ();
  always #12.5 core_clk_i = ~core_clk_i;
  ach_host #(.SETTLE_CYC(10)) u_ach_host (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link(link), .start_req_i(start_req_i), .ref_changed_i(ref_changed_i),
    .ready_o(ready_o), .result_valid_o(result_valid_o), .result_o(result_o));
  ach_device u_ach_device (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link),
    .sample_i(sample_i), .sampled_o());
  ach_device u_ach_device_2 (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link2),
    .sample_i(sample2_i), .sampled_o());
  ach_chk u_ach_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .conversion_start_n(link.conversion_start_n), .busy_n(link.busy_n), .data(link.data));
  task automatic check(input string what, input ach_word_t exp, input ach_word_t got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk_i);
    #2;
  endtask
  // bounded waits; a hang shows as a mismatch, not a stall
  task automatic wait_ready(input logic lvl);
    cyc = 0;
    while (ready_o !== lvl && cyc < 200) begin
      step();
      cyc++;
    end
    check("ready wait", 14'(lvl), 14'(ready_o));
  endtask
  task automatic wait_busy2(input logic lvl);
    cyc = 0;
    while (link2.busy_n !== lvl && cyc < 50) begin
      step();
      cyc++;
    end
    check("busy2 wait", 14'(lvl), 14'(link2.busy_n));
  endtask
  // ----------------------------------------
  // monitor: results, wire data, early latch
  // ----------------------------------------
  // watched on the falling edge, where launched outputs have settled
  always @(negedge core_clk_i) begin
    if (link.busy_n === 1'b1 && prev_busy === 1'b0) begin
      check("wire data", exp_q[0], link.data);
      rise_age = 0;
    end else rise_age++;
    if (link.busy_n === 1'b0 && prev_busy === 1'b1) check("early latch", last_w, link.data);
    if (result_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("unexpected result: expected none seen %h", result_o);
      end else begin
        last_w = exp_q.pop_front();
        check("result", last_w, result_o);
      end
      check("setup gap", 14'h0001, 14'(rise_age >= `ACH_SETUP_CYC));
    end
    prev_busy = link.busy_n;
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    link2.conversion_start_n = 1'b1;
    repeat (12) @(posedge core_clk_i);
    #2;
    resetn_i = 1'b1;
    repeat (5) step();
    check("ready in settle", 14'h0000, 14'(ready_o));
    for (int i = 0; i < 12; i++) begin
      wait_ready(1'b1);
      if (i == 6) begin
        ref_changed_i = 1'b1;
        step();
        ref_changed_i = 1'b0;
        repeat (4) step();
        check("ready after ref", 14'h0000, 14'(ready_o));
        wait_ready(1'b1);
      end
      sample_i = (i == 0) ? 14'h1FFF : (i == 1) ? 14'h2000 : 14'($random(seed));
      exp_q.push_back(sample_i);
      start_req_i = 1'b1;
      wait_ready(1'b0);
      start_req_i = 1'b0;
    end
    wait_ready(1'b1);
    // direct drive: extra fall mid-conversion, start held low over busy rise
    sample2_i = 14'h2AAA;
    link2.conversion_start_n = 1'b0;
    repeat (6) step();
    link2.conversion_start_n = 1'b1;
    step();
    link2.conversion_start_n = 1'b0;
    sample2_i = 14'h1555;
    wait_busy2(1'b1);
    // two sampler flops plus the detect edge, then the conversion count
    check("conv span", 14'(`ACH_CONV_CYC + 3), 14'(cyc + 7));
    repeat (5) step();
    check("busy held", 14'h0001, 14'(link2.busy_n));
    check("first sample", 14'h2AAA, link2.data);
    link2.conversion_start_n = 1'b1;
    step();
    link2.conversion_start_n = 1'b0;
    wait_busy2(1'b0);
    wait_busy2(1'b1);
    check("next sample", 14'h1555, link2.data);
    report_and_stop();
  end
  initial begin
    #200000;
    n_errors++;
    $display("unexpected watchdog: expected done seen timeout");
    report_and_stop();
  end
endmodule // test_adc_conversion_handshake

// *** verilog/ach_defines.svh ***
// timing and width constants for the conversion handshake
`ifndef ACH_DEFINES_SVH
`define ACH_DEFINES_SVH
`define ACH_CLK_PERIOD_NS 25
`define ACH_DATA_W 14
`define ACH_CONV_TYP_NS 330
`define ACH_CONV_MAX_NS 400
`define ACH_ACQ_MAX_NS 100
`define ACH_THRU_NS 454
`define ACH_SETUP_NS 20
`define ACH_REF_SETTLE_MS 5
// host holds start low this many cycles so the two-flop sampler sees it
`define ACH_START_LOW_CYC 5
// conversion: typical time, rounded down so the maximum is never exceeded
`define ACH_CONV_CYC (`ACH_CONV_TYP_NS / `ACH_CLK_PERIOD_NS)
// data setup after busy rises: least time, rounded up
`define ACH_SETUP_CYC ((`ACH_SETUP_NS + `ACH_CLK_PERIOD_NS - 1) / `ACH_CLK_PERIOD_NS)
// start spacing: least time, rounded up
`define ACH_THRU_CYC ((`ACH_THRU_NS + `ACH_CLK_PERIOD_NS - 1) / `ACH_CLK_PERIOD_NS)
// reference settle: 5 ms at 40 MHz
`define ACH_REF_SETTLE_CYC (`ACH_REF_SETTLE_MS * 1000000 / `ACH_CLK_PERIOD_NS)
`define ACH_CNT_W 18
`endif

// *** verilog/ach_device.sv ***
// converter end: start detection, conversion timing, result port
`timescale 1ns/1ps
`include "ach_defines.svh"
// Functional notes
// - falling start edge begins conversion, samples input
// - starts ignored while converting
// - busy low throughout conversion, high after
// - result bus updates as busy rises
// - host samples data 20ns after busy
// - early latch yields previous conversion result
// - 14-bit two's complement parallel result
// - conversion typical 330ns, at most 400ns
// - acquisition 100ns, start every 454ns
// - code step one part in 16384
// - host waits 5ms after reference change
module ach_device
  import ach_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  ach_if.device link,
  input wire logic [`ACH_DATA_W-1:0] sample_i,
  output logic sampled_o
);
  // ---------------------------------------------------------------
  // start synchroniser
  // ---------------------------------------------------------------
  logic start_meta_reg;
  logic start_sync_reg;
  logic start_last_reg;
  logic start_fall;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_meta_reg <= 1'b1;
      start_sync_reg <= 1'b1;
      start_last_reg <= 1'b1;
    end else begin
      start_meta_reg <= link.conversion_start_n;
      start_sync_reg <= start_meta_reg;
      start_last_reg <= start_sync_reg;
    end
  end
  assign start_fall = start_last_reg & ~start_sync_reg;
  // ---------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------
  ach_dev_state_e state_reg;
  ach_cnt_t cnt_reg;
  ach_word_t hold_reg;
  ach_word_t data_reg;
  logic busy_n_reg;
  logic sampled_reg;
  logic done;
  assign done = (state_reg == ACH_DEV_CONV) && (cnt_reg == ach_cnt_t'(`ACH_CONV_CYC - 1));
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ACH_DEV_IDLE;
    end else begin
      unique case (state_reg)
        ACH_DEV_IDLE: begin
          if (start_fall) begin
            state_reg <= ACH_DEV_CONV;
          end
        end
        ACH_DEV_CONV: begin
          // further starts are not looked at here
          if (done) begin
            state_reg <= ACH_DEV_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (state_reg == ACH_DEV_CONV) begin
      cnt_reg <= cnt_reg + ach_cnt_t'(1);
    end else begin
      cnt_reg <= '0;
    end
  end
  // sample held at the start edge; the digitised value is already two's complement
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_reg <= '0;
    end else if (state_reg == ACH_DEV_IDLE && start_fall) begin
      hold_reg <= sample_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sampled_reg <= 1'b0;
    end else begin
      sampled_reg <= (state_reg == ACH_DEV_IDLE) && start_fall;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_n_reg <= 1'b1;
    end else if (state_reg == ACH_DEV_IDLE && start_fall) begin
      busy_n_reg <= 1'b0;
    end else if (done) begin
      busy_n_reg <= 1'b1;
    end
  end
  // data changes only with busy rising, so earlier latches see the old word
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_reg <= '0;
    end else if (done) begin
      data_reg <= hold_reg;
    end
  end
  assign link.busy_n = busy_n_reg;
  assign link.data = data_reg;
  assign sampled_o = sampled_reg;
endmodule // ach_device

// *** verilog/ach_host.sv ***
// host end: paced starts and result capture
`timescale 1ns/1ps
`include "ach_defines.svh"
module ach_host
  import ach_pkg::*;
#(
  parameter int SETTLE_CYC = `ACH_REF_SETTLE_CYC
)
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  ach_if.host link,
  input wire logic start_req_i,
  input wire logic ref_changed_i,
  output logic ready_o,
  output logic result_valid_o,
  output logic [`ACH_DATA_W-1:0] result_o
);
  // ---------------------------------------------------------------
  // busy synchroniser
  // ---------------------------------------------------------------
  logic busy_meta_reg;
  logic busy_sync_reg;
  logic busy_last_reg;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_meta_reg <= 1'b1;
      busy_sync_reg <= 1'b1;
      busy_last_reg <= 1'b1;
    end else begin
      busy_meta_reg <= link.busy_n;
      busy_sync_reg <= busy_meta_reg;
      busy_last_reg <= busy_sync_reg;
    end
  end
  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  ach_host_state_e state_reg;
  ach_cnt_t cnt_reg;
  ach_cnt_t gap_reg;
  logic start_n_reg;
  logic valid_reg;
  ach_word_t result_reg;
  logic busy_rise;
  logic go;
  assign busy_rise = ~busy_last_reg & busy_sync_reg;
  assign go = (state_reg == ACH_HOST_READY) && start_req_i && (gap_reg == '0);
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ACH_HOST_SETTLE;
      cnt_reg <= '0;
    end else if (ref_changed_i) begin
      state_reg <= ACH_HOST_SETTLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ACH_HOST_SETTLE: begin
          cnt_reg <= cnt_reg + ach_cnt_t'(1);
          if (cnt_reg >= ach_cnt_t'(SETTLE_CYC - 1)) begin
            state_reg <= ACH_HOST_READY;
          end
        end
        ACH_HOST_READY: begin
          cnt_reg <= '0;
          if (go) begin
            state_reg <= ACH_HOST_WAIT;
          end
        end
        ACH_HOST_WAIT: begin
          if (busy_rise) begin
            state_reg <= ACH_HOST_SETUP;
          end
        end
        ACH_HOST_SETUP: begin
          cnt_reg <= cnt_reg + ach_cnt_t'(1);
          // synchroniser delay already exceeds the setup, count adds margin
          if (cnt_reg >= ach_cnt_t'(`ACH_SETUP_CYC - 1)) begin
            state_reg <= ACH_HOST_READY;
            cnt_reg <= '0;
          end
        end
      endcase
    end
  end
  // spacing between start edges
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_reg <= '0;
    end else if (go) begin
      gap_reg <= ach_cnt_t'(`ACH_THRU_CYC - 1);
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - ach_cnt_t'(1);
    end
  end
  // start held low for a few cycles so the device sees the edge
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_n_reg <= 1'b1;
    end else if (go) begin
      start_n_reg <= 1'b0;
    end else if (gap_reg == ach_cnt_t'(`ACH_THRU_CYC - `ACH_START_LOW_CYC)) begin
      start_n_reg <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (state_reg == ACH_HOST_SETUP && cnt_reg >= ach_cnt_t'(`ACH_SETUP_CYC - 1)
          && !ref_changed_i) begin
        result_reg <= link.data;
        valid_reg <= 1'b1;
      end
    end
  end
  logic ready_reg;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == ACH_HOST_READY) && !go && !ref_changed_i;
    end
  end
  assign link.conversion_start_n = start_n_reg;
  assign ready_o = ready_reg;
  assign result_valid_o = valid_reg;
  assign result_o = result_reg;
endmodule // ach_host

// *** verilog/ach_if.sv ***
// pins between converter and host
`timescale 1ns/1ps
`include "ach_defines.svh"
interface ach_if;
  logic conversion_start_n;
  logic busy_n;
  logic [`ACH_DATA_W-1:0] data;
  modport device (input conversion_start_n, output busy_n, output data);
  modport host (output conversion_start_n, input busy_n, input data);
endinterface

// *** verilog/ach_pkg.sv ***
// types shared by both ends of the conversion handshake
package ach_pkg;
  `include "ach_defines.svh"
  typedef logic [`ACH_DATA_W-1:0] ach_word_t;
  typedef logic [`ACH_CNT_W-1:0] ach_cnt_t;
  typedef enum logic [1:0] {
    ACH_DEV_IDLE = 2'b01,
    ACH_DEV_CONV = 2'b10
  } ach_dev_state_e;
  typedef enum logic [3:0] {
    ACH_HOST_SETTLE = 4'b0001,
    ACH_HOST_READY = 4'b0010,
    ACH_HOST_WAIT = 4'b0100,
    ACH_HOST_SETUP = 4'b1000
  } ach_host_state_e;
endpackage
